//--- adc_seq_pkg.sv
// package: register map, field layout and phase timing of the conversion sequencer
package adc_seq_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0]  CTRL_INDEX    = 10'h0C5;
  localparam logic [9:0]  RESULT_INDEX  = 10'h0C6;
  localparam logic [9:0]  IRQ_STS_INDEX = 10'h0C7;
  localparam logic [9:0]  IRQ_MSK_INDEX = 10'h0C8;
  localparam int          ADDR_W        = 12;
  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int          RES_B1_POS    = 7;
  localparam int          RES_B0_POS    = 6;
  localparam int          EXT_EN_POS    = 5;
  localparam int          DONE_POS      = 4;
  localparam int          START_POS     = 3;
  localparam int          CHAN_MSB      = 2;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  RESULT_RESET  = 8'h00;
  localparam logic [0:0]  IRQ_RESET     = 1'h0;
  // ----------------------------------------------------------------
  // timing in machine cycles
  // ----------------------------------------------------------------
  localparam int          INIT_TICKS    = 2;
  localparam int          SAMPLE_TICKS  = 8;
  localparam int          TICKS_PER_BIT = 4;
  localparam int          RESULT_BITS   = 10;
  localparam int          TOTAL_TICKS   = INIT_TICKS + SAMPLE_TICKS
                                          + TICKS_PER_BIT * RESULT_BITS;
  // sequencer phases
  typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_SAMPLE, ST_CONVERT} phase_t;
  // software-visible control fields
  typedef struct packed {
    logic       ext_en;
    logic       done;
    logic       busy;
    logic [2:0] chan;
  } ctrl_t;
endpackage : adc_seq_pkg

//--- adc_conversion_sequencer.sv
// module: successive-approximation converter sequencer with an APB register slave
// ------------------------------------------------------------------
// Overview of operation
// - a full conversion takes 50 machine cycles from start to result ready
// - on completion upper eight bits go to result byte, low two to control
// - control bit 7 holds result bit 1, bit 6 result bit 0, read-only
// - start requests during a running conversion are ignored
// - the stored result stays unchanged while the done flag is set
// - starts arriving while busy, or while done stays set, are discarded, not queued
// - entering idle or power-down aborts a conversion in progress
// - during idle a completed result and its done flag stay intact
// - external rising edge seen at cycle end starts the next machine cycle
// - software start begins at the machine cycle after the writing one
// - two init cycles; busy rises after the first, sampling after the second
// - the selected channel is sampled for eight machine cycles
// - each result bit is resolved in four machine cycles
// - control bit 5 enables the external start input as a trigger
// - control bit 4 is done; hardware sets it, software only clears it
// - control bit 3 starts and shows busy; cleared as done sets
// - bits 2..0 select the channel, writable only while idle and not done
// - clearing done in the same write as setting start may start a conversion
// ------------------------------------------------------------------
`timescale 1ns/1ps
module adc_conversion_sequencer
(
  // clock and reset
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_i,
  // apb slave
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                    pwdata_i,
  output logic      [31:0]                    prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  // processor core status
  input  wire logic                           machine_tick_i,
  input  wire logic                           idle_mode_i,
  input  wire logic                           power_down_i,
  // external start pin
  input  wire logic                           external_start_input_i,
  // analog macro
  input  wire logic                           comparator_i,
  output logic      [2:0]                     channel_o,
  output logic                                sample_o,
  output logic      [9:0]                     trial_code_o,
  // interrupt
  output logic                                irq_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adc_seq_pkg::phase_t state;
  adc_seq_pkg::ctrl_t  ctrl;
  logic [5:0]          tick_cnt;
  logic [3:0]          bit_idx;
  logic [9:0]          sar;
  logic [7:0]          result_high;
  logic [1:0]          result_low;
  logic                pending;
  logic                irq_sts;
  logic                irq_msk;
  logic                ext_meta;
  logic                ext_sync;
  logic                ext_prev;
  logic                wr_en;
  logic                ext_edge;
  logic                abort;
  logic                finish;
  logic                begin_conv;
  logic                sw_clr_done;
  logic                sw_start;

  // word index of a byte address; unaligned addresses never match
  function automatic logic [9:0] reg_index(input logic [adc_seq_pkg::ADDR_W-1:0] a);
    reg_index = a[11:2];
  endfunction : reg_index

  function automatic logic hits(input logic [adc_seq_pkg::ADDR_W-1:0] a,
                                input logic [9:0] idx);
    hits = (a[1:0] == 2'h0) && (reg_index(a) == idx);
  endfunction : hits

  // ----------------------------------------------------------------
  // apb access decode
  // ----------------------------------------------------------------
  // the write lands at the access edge where pready is high
  assign wr_en       = psel_i && penable_i && pready_o && pwrite_i;
  assign sw_clr_done = wr_en && hits(paddr_i, adc_seq_pkg::CTRL_INDEX)
                       && !pwdata_i[adc_seq_pkg::DONE_POS];
  assign sw_start    = wr_en && hits(paddr_i, adc_seq_pkg::CTRL_INDEX)
                       && pwdata_i[adc_seq_pkg::START_POS];

  // one wait-free cycle: pready and read data are prepared in setup
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      pready_o  <= psel_i && !penable_i && !pready_o;
      pslverr_o <= 1'b0;
      if (psel_i && !penable_i)
      begin
        prdata_o <= 32'h0000_0000;
        if (hits(paddr_i, adc_seq_pkg::CTRL_INDEX))
          prdata_o[7:0] <= {result_low, ctrl};
        else if (hits(paddr_i, adc_seq_pkg::RESULT_INDEX))
          prdata_o[7:0] <= result_high;
        else if (hits(paddr_i, adc_seq_pkg::IRQ_STS_INDEX))
          prdata_o[0] <= irq_sts;
        else if (hits(paddr_i, adc_seq_pkg::IRQ_MSK_INDEX))
          prdata_o[0] <= irq_msk;
        else
          pslverr_o <= 1'b1;                                   // unmapped
      end
    end
  end

  // ----------------------------------------------------------------
  // external start pin synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end
    else
    begin
      ext_meta <= external_start_input_i;
      ext_sync <= ext_meta;
    end
  end

  // the pin is looked at only at machine-cycle ends, so short glitches between are missed
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ext_prev <= 1'b0;
    else if (machine_tick_i)
      ext_prev <= ext_sync;
  end

  assign ext_edge = machine_tick_i && ext_sync && !ext_prev && ctrl.ext_en;

  // ----------------------------------------------------------------
  // start acceptance and phase control
  // ----------------------------------------------------------------
  assign abort      = idle_mode_i || power_down_i;
  assign finish     = machine_tick_i && (state == adc_seq_pkg::ST_CONVERT)
                      && (bit_idx == 4'h0)
                      && (tick_cnt == 6'(adc_seq_pkg::TICKS_PER_BIT - 1));
  assign begin_conv = machine_tick_i && !abort && (state == adc_seq_pkg::ST_IDLE)
                      && !ctrl.done && (pending || ext_edge);

  // a software start waits for the end of the current machine cycle
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pending <= 1'b0;
    else if (begin_conv || abort)
      pending <= 1'b0;
    else if (sw_start && (state == adc_seq_pkg::ST_IDLE) && !pending
             && (!ctrl.done || sw_clr_done))
      pending <= 1'b1;
  end

  // phase sequencer, every phase counted in ticks
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state    <= adc_seq_pkg::ST_IDLE;
      tick_cnt <= 6'h00;
      bit_idx  <= 4'h0;
    end
    else if (abort)
    begin
      state    <= adc_seq_pkg::ST_IDLE;
      tick_cnt <= 6'h00;
    end
    else if (machine_tick_i)
    begin
      unique case (state)
        adc_seq_pkg::ST_IDLE:
        begin
          tick_cnt <= 6'h00;
          if (begin_conv)
            state <= adc_seq_pkg::ST_INIT;
        end
        adc_seq_pkg::ST_INIT:
        begin
          tick_cnt <= tick_cnt + 6'h01;
          if (tick_cnt == 6'(adc_seq_pkg::INIT_TICKS - 1))
          begin
            state    <= adc_seq_pkg::ST_SAMPLE;
            tick_cnt <= 6'h00;
          end
        end
        adc_seq_pkg::ST_SAMPLE:
        begin
          tick_cnt <= tick_cnt + 6'h01;
          if (tick_cnt == 6'(adc_seq_pkg::SAMPLE_TICKS - 1))
          begin
            state    <= adc_seq_pkg::ST_CONVERT;
            tick_cnt <= 6'h00;
            bit_idx  <= 4'(adc_seq_pkg::RESULT_BITS - 1);
          end
        end
        adc_seq_pkg::ST_CONVERT:
        begin
          tick_cnt <= tick_cnt + 6'h01;
          if (tick_cnt == 6'(adc_seq_pkg::TICKS_PER_BIT - 1))
          begin
            tick_cnt <= 6'h00;
            bit_idx  <= bit_idx - 4'h1;
            if (bit_idx == 4'h0)
              state <= adc_seq_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // successive approximation and analog controls
  // ----------------------------------------------------------------
  // the trial keeps the decided bits and tests the current one
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sar          <= 10'h000;
      trial_code_o <= 10'h000;
    end
    else if (state == adc_seq_pkg::ST_SAMPLE && tick_cnt == 6'h00)
    begin
      sar          <= 10'h000;
      trial_code_o <= 10'h200;
    end
    else if (machine_tick_i && state == adc_seq_pkg::ST_CONVERT
             && tick_cnt == 6'(adc_seq_pkg::TICKS_PER_BIT - 1))
    begin
      sar[bit_idx]          <= comparator_i;
      trial_code_o          <= sar;
      trial_code_o[bit_idx] <= comparator_i;
      if (bit_idx != 4'h0)
        trial_code_o[bit_idx - 4'h1] <= 1'b1;
    end
  end

  // channel follows the register, which cannot move once initiation began
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      channel_o <= 3'h0;
      sample_o  <= 1'b0;
    end
    else
    begin
      channel_o <= ctrl.chan;
      sample_o  <= (state == adc_seq_pkg::ST_SAMPLE) && !abort;
    end
  end

  // ----------------------------------------------------------------
  // control, result and interrupt registers
  // ----------------------------------------------------------------
  // done: hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl <= adc_seq_pkg::ctrl_t'(adc_seq_pkg::CTRL_RESET[5:0]);
    else
    begin
      if (finish && !abort)
      begin
        ctrl.done <= 1'b1;
        ctrl.busy <= 1'b0;
      end
      else if (sw_clr_done)
        ctrl.done <= 1'b0;
      if (abort)
        ctrl.busy <= 1'b0;
      else if (machine_tick_i && state == adc_seq_pkg::ST_INIT && tick_cnt == 6'h00)
        ctrl.busy <= 1'b1;
      if (wr_en && hits(paddr_i, adc_seq_pkg::CTRL_INDEX))
      begin
        ctrl.ext_en <= pwdata_i[adc_seq_pkg::EXT_EN_POS];
        if (state == adc_seq_pkg::ST_IDLE && !pending && !ctrl.done && !ctrl.busy)
          ctrl.chan <= pwdata_i[adc_seq_pkg::CHAN_MSB:0];
      end
    end
  end

  // result loads only at completion, which cannot happen while done is set
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      result_high <= adc_seq_pkg::RESULT_RESET;
      result_low  <= 2'h0;
    end
    else if (finish && !abort)
    begin
      result_high <= sar[9:2];
      result_low  <= {sar[1], comparator_i};
    end
  end

  // completion event sticky bit, cleared by writing one, and mask
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_sts <= adc_seq_pkg::IRQ_RESET;
      irq_msk <= adc_seq_pkg::IRQ_RESET;
      irq_o   <= 1'b0;
    end
    else
    begin
      if (finish && !abort)
        irq_sts <= 1'b1;
      else if (wr_en && hits(paddr_i, adc_seq_pkg::IRQ_STS_INDEX) && pwdata_i[0])
        irq_sts <= 1'b0;
      if (wr_en && hits(paddr_i, adc_seq_pkg::IRQ_MSK_INDEX))
        irq_msk <= pwdata_i[0];
      irq_o <= irq_sts && irq_msk;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [6:0] run_ticks;
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      run_ticks <= 7'h00;
    else if (state == adc_seq_pkg::ST_IDLE)
      run_ticks <= begin_conv ? 7'h01 : 7'h00;
    else if (machine_tick_i)
      run_ticks <= run_ticks + 7'h01;
  end

  sequence s_first_init;
    machine_tick_i && state == adc_seq_pkg::ST_INIT && tick_cnt == 6'h00 && !abort;
  endsequence
  sequence s_enter_sample;
    $rose(state == adc_seq_pkg::ST_SAMPLE);
  endsequence

  a_total_length: assert property (@(posedge core_clk_i) disable iff (rst_i)
    finish && !abort |-> run_ticks == 7'(adc_seq_pkg::TOTAL_TICKS))
    else $error("conversion length is not 50 machine cycles");
  a_busy_raise: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_first_init |=> ctrl.busy)
    else $error("busy did not rise after first init cycle");
  a_sample_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_enter_sample ##0 !abort |=> sample_o)
    else $error("sampling did not begin with the sample phase");
  a_done_clears_busy: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(ctrl.done) |-> !ctrl.busy && $past(ctrl.busy))
    else $error("busy not cleared as done set");
  a_result_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctrl.done && $past(ctrl.done) |-> $stable(result_high) && $stable(result_low))
    else $error("result changed while done set");
  a_start_blocked: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == adc_seq_pkg::ST_IDLE && ctrl.done |=> state == adc_seq_pkg::ST_IDLE)
    else $error("conversion started while done set");
  a_abort_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    abort |=> state == adc_seq_pkg::ST_IDLE && !ctrl.busy)
    else $error("conversion not aborted on low-power entry");
  a_done_kept: assert property (@(posedge core_clk_i) disable iff (rst_i)
    idle_mode_i && ctrl.done && !sw_clr_done |=> ctrl.done)
    else $error("done lost during idle");
  a_chan_steady: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state != adc_seq_pkg::ST_IDLE |=> $stable(ctrl.chan))
    else $error("channel changed during conversion");
  a_ext_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == adc_seq_pkg::ST_IDLE && !pending && !ctrl.ext_en |=> state == adc_seq_pkg::ST_IDLE)
    else $error("external start accepted while disabled");

endmodule : adc_conversion_sequencer

//--- core_model.sv
// partner model: processor core tick source and ideal analog front end
`timescale 1ns/1ps
module core_model
#(
  parameter int          TICK_DIV = 4,
  parameter logic [79:0] LEVELS   = 80'h0
)
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // analog macro side
  input  wire logic [2:0] channel_i,
  input  wire logic [9:0] trial_code_i,
  output logic            comparator_o,
  // machine cycle marker
  output logic            machine_tick_o
);
  int div_cnt;

  // one-cycle pulse closing each machine cycle, the unit of every phase
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_cnt        <= 0;
      machine_tick_o <= 1'b0;
    end
    else
    begin
      div_cnt        <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      machine_tick_o <= (div_cnt == TICK_DIV - 1);
    end
  end

  // ideal comparator; levels are constant so the sampled input stays stable
  assign comparator_o = (LEVELS[channel_i*10 +: 10] >= trial_code_i);
endmodule : core_model

//--- testbench.sv
// testbench: register-level tests of the conversion sequencer
`timescale 1ns/1ps
module testbench;
  localparam int          TICK_DIV = 4;
  localparam logic [79:0] LEVELS   = {10'h0F0, 10'h135, 10'h3A9, 10'h2D6,
                                      10'h0AA, 10'h155, 10'h3FF, 10'h001};
  localparam logic [11:0] A_CTRL   = {adc_seq_pkg::CTRL_INDEX, 2'b00};
  localparam logic [11:0] A_RES    = {adc_seq_pkg::RESULT_INDEX, 2'b00};
  localparam logic [11:0] A_STS    = {adc_seq_pkg::IRQ_STS_INDEX, 2'b00};
  localparam logic [11:0] A_MSK    = {adc_seq_pkg::IRQ_MSK_INDEX, 2'b00};
  localparam logic [9:0]  LV4      = LEVELS[40 +: 10];
  localparam logic [9:0]  LV6      = LEVELS[60 +: 10];
  logic        core_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic        machine_tick_i, idle_mode_i, power_down_i, ext_i, comparator_i;
  logic        sample_o, irq_o, irq_prev, last_err;
  logic [2:0]  channel_o;
  logic [9:0]  trial_code_o;
  int          n_errors, num_checks, tick_cnt, samp_cnt, wr_mark, irq_tick, m0;

  adc_conversion_sequencer i_adc_conversion_sequencer (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .machine_tick_i(machine_tick_i), .idle_mode_i(idle_mode_i),
    .power_down_i(power_down_i), .external_start_input_i(ext_i),
    .comparator_i(comparator_i), .channel_o(channel_o), .sample_o(sample_o),
    .trial_code_o(trial_code_o), .irq_o(irq_o));
  core_model #(.TICK_DIV(TICK_DIV), .LEVELS(LEVELS)) i_core_model (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .channel_i(channel_o), .trial_code_i(trial_code_o),
    .comparator_o(comparator_i), .machine_tick_o(machine_tick_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // tick bookkeeping: marks of control writes, sample ticks, interrupt arrival
  always @(posedge core_clk_i)
  begin
    if (machine_tick_i === 1'b1) tick_cnt <= tick_cnt + 1;
    if (machine_tick_i === 1'b1 && sample_o === 1'b1) samp_cnt <= samp_cnt + 1;
    if (psel_i && penable_i && pready_o === 1'b1 && pwrite_i && paddr_i == A_CTRL)
    begin
      wr_mark  <= tick_cnt + int'(machine_tick_i);
      samp_cnt <= 0;
    end
    if (irq_o === 1'b1 && irq_prev !== 1'b1) irq_tick <= tick_cnt;
    irq_prev <= irq_o;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge core_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1)
    begin
      n_errors++;
      results();
    end
    r         = prdata_o;
    last_err  = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(what, exp, r);
  endtask : rd_chk

  task automatic ticks(input int k);
    repeat (k * TICK_DIV) @(posedge core_clk_i);
  endtask : ticks

  task automatic wait_irq();
    int n;
    for (n = 0; n < 600 && irq_o !== 1'b1; n++) @(posedge core_clk_i);
    if (irq_o !== 1'b1)
    begin
      n_errors++;
      results();
    end
    @(posedge core_clk_i);
  endtask : wait_irq

  initial
  begin
    {rst_i, psel_i, penable_i, pwrite_i, idle_mode_i, power_down_i, ext_i} = 7'h40;
    {paddr_i, pwdata_i, n_errors, num_checks, tick_cnt, samp_cnt} = '0;
    {wr_mark, irq_tick, irq_prev} = '0;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped and read-only places
    rd_chk("ctrl reset", A_CTRL, 32'h0);
    rd_chk("result reset", A_RES, 32'h0);
    rd_chk("status reset", A_STS, 32'h0);
    rd_chk("mask reset", A_MSK, 32'h0);
    chk("mapped no error", 32'h0, {31'h0, last_err});
    rd_chk("unmapped read", 12'h400, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, last_err});
    rd_chk("unaligned read", A_CTRL + 12'h001, 32'h0);
    chk("unaligned error", 32'h1, {31'h0, last_err});
    wr(A_CTRL, 32'hD0);
    rd_chk("done and result not writable", A_CTRL, 32'h0);
    $display("test reset done");
    // software start on input four, timed in ticks
    wr(A_MSK, 32'h1);
    wr(A_CTRL, 32'h04);
    wr(A_CTRL, 32'h0C);
    wait_irq();
    // the machine cycle holding the write closes first, then 50 more
    chk("ticks to done", 32'd51, irq_tick - wr_mark);
    chk("sample ticks", 32'd8, samp_cnt);
    rd_chk("result high", A_RES, {24'h0, LV4[9:2]});
    rd_chk("ctrl after done", A_CTRL, {24'h0, LV4[1:0], 6'h14});
    chk("channel out", 32'h4, {29'h0, channel_o});
    $display("test software start done");
    // start and channel change while done, then idle with a result
    wr(A_CTRL, 32'h1A);
    ticks(60);
    idle_mode_i <= 1'b1;
    ticks(4);
    idle_mode_i <= 1'b0;
    rd_chk("ctrl kept", A_CTRL, {24'h0, LV4[1:0], 6'h14});
    rd_chk("result kept", A_RES, {24'h0, LV4[9:2]});
    chk("channel held", 32'h4, {29'h0, channel_o});
    $display("test blocked start done");
    // interrupt mask and clear
    wr(A_MSK, 32'h0);
    ticks(1);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wr(A_MSK, 32'h1);
    ticks(1);
    chk("irq unmasked", 32'h1, {31'h0, irq_o});
    wr(A_STS, 32'h1);
    ticks(1);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    $display("test interrupt done");
    // clear done and start in one write; a start and channel write while busy
    wr(A_CTRL, 32'h0C);
    @(posedge core_clk_i);
    m0 = wr_mark;
    ticks(3);
    rd_chk("busy", A_CTRL, {24'h0, LV4[1:0], 6'h0C});
    wr(A_CTRL, 32'h0D);
    wait_irq();
    chk("busy restart ignored", 32'd51, irq_tick - m0);
    rd_chk("result same input", A_RES, {24'h0, LV4[9:2]});
    wr(A_STS, 32'h1);
    wr(A_CTRL, 32'h04);
    $display("test restart done");
    // abort by power-down, then by idle
    for (int k = 0; k < 2; k++)
    begin
      wr(A_CTRL, 32'h0C);
      ticks(20);
      {idle_mode_i, power_down_i} <= k ? 2'b10 : 2'b01;
      ticks(2);
      {idle_mode_i, power_down_i} <= 2'b00;
      ticks(60);
      rd_chk("aborted ctrl", A_CTRL, {24'h0, LV4[1:0], 6'h04});
      rd_chk("aborted status", A_STS, 32'h0);
    end
    $display("test abort done");
    // external start, disabled then enabled
    wr(A_CTRL, 32'h06);
    ext_i <= 1'b1;
    ticks(3);
    ext_i <= 1'b0;
    ticks(60);
    rd_chk("ext disabled", A_STS, 32'h0);
    wr(A_CTRL, 32'h26);
    ticks(2);
    ext_i <= 1'b1;
    wait_irq();
    ext_i <= 1'b0;
    rd_chk("ext result", A_RES, {24'h0, LV6[9:2]});
    rd_chk("ext ctrl", A_CTRL, {24'h0, LV6[1:0], 6'h36});
    $display("test external start done");
    results();
  end
endmodule : testbench
